// ### cssf_top.sv
`timescale 1ns/1ns
`default_nettype none
// Function
// - with the internal clock the transfer rate is the divider output halved.
// - the divider count source is the main clock divided by 1, 8 or 32.
// - with the external clock data shifts at the pin clock rate, undivided.
// - fault detection runs only in master mode.
// - in master mode a low select input floats the clock, output and input pins.
// - a fault sets the fault flag and raises the fault interrupt request.
// - clearing the fault flag restores the clock and data outputs.
// - in master mode a clear of the fault flag works only while select is high.
// - in slave mode a clear of the fault flag always works.
// - polarity picks sample-falling/change-rising or sample-rising/change-falling.
// - phase picks a transfer clock with or without delay against the data.
// - a role setting makes the port master or slave.
// - the clock pin drives when internal and master, listens when external, and floats unused as an internal slave; data pins are fixed.
module cssf_top (
   input wire logic clk,
   input wire logic rst,
   input wire cssf_pkg::cssf_cfg_t cfg,
   input wire logic start,
   input wire logic [7:0] tx_byte,
   input wire logic fault_clear,
   input wire logic transfer_clock_pin_i,
   input wire logic serial_in_pin,
   input wire logic bus_select_input,
   output cssf_pkg::cssf_pins_t pins,
   output logic busy,
   output logic [7:0] rx_byte,
   output logic rx_done,
   output logic fault_flag,
   output logic fault_irq
);
   // pin synchronisers, first stage read only by the second
   logic [2:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;
   logic eclk, ein, esel;
   always_comb begin
      s1_d = {transfer_clock_pin_i, serial_in_pin, bus_select_input};
      s2_d = s1_q;
      s3_d = s2_q;
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= 3'h7;
         s2_q <= 3'h7;
         s3_q <= 3'h7;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
      end
   end
   assign eclk = s2_q[2];
   assign ein = s2_q[1];
   assign esel = s2_q[0];

   // prescaler and bit rate divider; one pulse per half bit
   logic [4:0] pre_q, pre_d;
   logic [7:0] brg_q, brg_d;
   logic pre_tick, half_tick, ext_rise, ext_fall;
   always_comb begin
      pre_d = pre_q + 5'h01;
      case (cfg.src)
         cssf_pkg::CSSF_SRC_DIV8: pre_tick = (pre_q[2:0] == cssf_pkg::CSSF_PRE_DIV8_LAST[2:0]);
         cssf_pkg::CSSF_SRC_DIV32: pre_tick = (pre_q == cssf_pkg::CSSF_PRE_DIV32_LAST);
         default: pre_tick = 1'b1;
      endcase
      brg_d = brg_q;
      half_tick = 1'b0;
      if (pre_tick) begin
         if (brg_q == 8'h00) begin
            brg_d = cfg.brg;
            half_tick = 1'b1;
         end else begin
            brg_d = brg_q - 8'h01;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         pre_q <= 5'h00;
         brg_q <= 8'h00;
      end else begin
         pre_q <= pre_d;
         brg_q <= brg_d;
      end
   end
   // external clock edges from the synchronised pin
   assign ext_rise = eclk & ~s3_q[2];
   assign ext_fall = ~eclk & s3_q[2];

   // shifter state
   cssf_pkg::cssf_state_t st_q, st_d;
   logic [7:0] sh_q, sh_d, rx_q, rx_d;
   logic [2:0] cnt_q, cnt_d;
   logic sclk_q, sclk_d, out_q, out_d, done_q, done_d, flt_q, flt_d;
   logic lead_edge, trail_edge, samp_edge, chg_edge, fault_now;
   always_comb begin
      // master only, low select means contention
      fault_now = cfg.master & ~esel;
      if (cfg.ext_clk) begin
         // edges taken straight from the pin
         // delayed phase swaps lead and trail so the sample edge keeps its polarity
         lead_edge = (cfg.pol_rise_out ^ cfg.phase_delay) ? ext_fall : ext_rise;
         trail_edge = (cfg.pol_rise_out ^ cfg.phase_delay) ? ext_rise : ext_fall;
      end else begin
         // two half-bit ticks per bit halve the rate
         lead_edge = half_tick & ~sclk_q;
         trail_edge = half_tick & sclk_q;
      end
      // leading edge samples unless delayed phase, then it changes
      samp_edge = cfg.phase_delay ? trail_edge : lead_edge;
      chg_edge = cfg.phase_delay ? lead_edge : trail_edge;
      st_d = st_q;
      sh_d = sh_q;
      rx_d = rx_q;
      cnt_d = cnt_q;
      sclk_d = sclk_q;
      out_d = out_q;
      done_d = 1'b0;
      case (st_q)
         cssf_pkg::CSSF_IDLE: begin
            sclk_d = 1'b0;
            if (start & ~flt_q) begin
               sh_d = tx_byte;
               cnt_d = 3'h0;
               out_d = tx_byte[7];
               st_d = cfg.phase_delay ? cssf_pkg::CSSF_LEAD : cssf_pkg::CSSF_SHIFT;
            end
         end
         cssf_pkg::CSSF_LEAD, cssf_pkg::CSSF_SHIFT: begin
            if (~cfg.ext_clk & half_tick) begin
               sclk_d = ~sclk_q;
            end
            if (samp_edge) begin
               sh_d = {sh_q[6:0], ein};
               st_d = cssf_pkg::CSSF_SHIFT;
               if (cnt_q == cssf_pkg::CSSF_BIT_LAST) begin
                  rx_d = {sh_q[6:0], ein};
                  done_d = 1'b1;
                  st_d = cssf_pkg::CSSF_IDLE;
               end
               cnt_d = cnt_q + 3'h1;
            end else if (chg_edge & (st_q == cssf_pkg::CSSF_SHIFT | cfg.phase_delay)) begin
               out_d = sh_q[7];
            end
         end
         default: st_d = cssf_pkg::CSSF_IDLE;
      endcase
      if (fault_now) begin
         st_d = cssf_pkg::CSSF_IDLE;
      end
      // clear gated by select only as master
      flt_d = flt_q;
      if (fault_clear & (~cfg.master | esel)) begin
         flt_d = 1'b0;
      end
      if (fault_now) begin
         flt_d = 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= cssf_pkg::CSSF_IDLE;
         sh_q <= cssf_pkg::CSSF_BYTE_RESET;
         rx_q <= cssf_pkg::CSSF_BYTE_RESET;
         cnt_q <= 3'h0;
         sclk_q <= 1'b0;
         out_q <= 1'b1;
         done_q <= 1'b0;
         flt_q <= 1'b0;
      end else begin
         st_q <= st_d;
         sh_q <= sh_d;
         rx_q <= rx_d;
         cnt_q <= cnt_d;
         sclk_q <= sclk_d;
         out_q <= out_d;
         done_q <= done_d;
         flt_q <= flt_d;
      end
   end

   // pin drive; the fault flag floats everything until cleared
   always_comb begin
      // idle level follows polarity, inverted by delayed phase
      // without the inversion a delayed frame would sample on the wrong pin edge
      pins.clk_o = sclk_q ^ cfg.pol_rise_out ^ cfg.phase_delay;
      // clock drives only when internal, master role
      // float while faulted, restore on clear
      pins.clk_oe_n = cfg.ext_clk | ~cfg.master | flt_q;
      pins.out_o = out_q;
      pins.out_oe_n = flt_q;
      pins.in_oe_n = 1'b1;
   end
   assign busy = (st_q != cssf_pkg::CSSF_IDLE);
   assign rx_byte = rx_q;
   assign rx_done = done_q;
   assign fault_flag = flt_q;
   assign fault_irq = flt_q;

   // fault arrives one cycle after a low synchronised select (esel) in master mode
   fault_set_a: assert property (@(posedge clk) disable iff (rst)
      (cfg.master & ~esel) |=> fault_flag)
      else $error("fault not flagged");
   slave_no_fault_a: assert property (@(posedge clk) disable iff (rst)
      (~cfg.master & ~fault_flag) |=> ~fault_flag)
      else $error("fault in slave mode");
   float_out_a: assert property (@(posedge clk) disable iff (rst)
      fault_flag |-> (pins.out_oe_n & pins.clk_oe_n & pins.in_oe_n))
      else $error("pins driven during fault");
   clear_block_a: assert property (@(posedge clk) disable iff (rst)
      (fault_flag & cfg.master & ~esel) |=> fault_flag)
      else $error("fault cleared with select low");
   clear_slave_a: assert property (@(posedge clk) disable iff (rst)
      (fault_flag & fault_clear & ~cfg.master) |=> ~fault_flag)
      else $error("slave clear ignored");
   restore_out_a: assert property (@(posedge clk) disable iff (rst)
      (~fault_flag) |-> ~pins.out_oe_n)
      else $error("output not restored");
   ext_float_a: assert property (@(posedge clk) disable iff (rst)
      cfg.ext_clk |-> pins.clk_oe_n)
      else $error("clock driven in external mode");
   sequence done_pulse_s;
      rx_done ##1 ~rx_done;
   endsequence
   done_once_a: assert property (@(posedge clk) disable iff (rst)
      $rose(rx_done) |-> done_pulse_s)
      else $error("done not one cycle");
   rate_half_a: assert property (@(posedge clk) disable iff (rst)
      (busy & ~cfg.ext_clk & ~half_tick & ~fault_now) |=> $stable(sclk_q))
      else $error("clock toggled off tick");
endmodule : cssf_top
`default_nettype wire

// ### cssf_pkg.sv
`default_nettype none
package cssf_pkg;
   // count source selection for the bit rate divider
   typedef enum logic [1:0] {
      CSSF_SRC_DIV1 = 2'b00,
      CSSF_SRC_DIV8 = 2'b01,
      CSSF_SRC_DIV32 = 2'b10
   } cssf_src_t;

   localparam logic [4:0] CSSF_PRE_DIV8_LAST = 5'h07;
   localparam logic [4:0] CSSF_PRE_DIV32_LAST = 5'h1f;
   localparam logic [2:0] CSSF_BIT_LAST = 3'h7;
   localparam logic [7:0] CSSF_BYTE_RESET = 8'h00;

   // transfer state
   typedef enum logic [1:0] {
      CSSF_IDLE = 2'b00,
      CSSF_LEAD = 2'b01,
      CSSF_SHIFT = 2'b10
   } cssf_state_t;

   // static configuration from software
   typedef struct packed {
      logic master;
      logic ext_clk;
      logic pol_rise_out;
      logic phase_delay;
      cssf_src_t src;
      logic [7:0] brg;
   } cssf_cfg_t;

   // pin outputs; oe_n low means driving
   typedef struct packed {
      logic clk_o;
      logic clk_oe_n;
      logic out_o;
      logic out_oe_n;
      logic in_oe_n;
   } cssf_pins_t;
endpackage : cssf_pkg
`default_nettype wire

// ### cssf_slave_model.sv
`timescale 1ns/1ns
`default_nettype none
// far-side slave; loads a byte between frames, shifts msb first
module cssf_slave_model (
   input wire logic sclk,
   input wire logic mosi,
   input wire logic ld,
   input wire logic [7:0] ld_byte,
   input wire logic smp_fall,
   input wire logic skip_first,
   output logic miso,
   output logic [7:0] got
);
   logic [7:0] sh;
   logic skip;
   initial begin
      sh = 8'h00;
      got = 8'h00;
      miso = 1'b1;
      skip = 1'b0;
   end
   // delayed phase: the first change edge must not lose the msb
   always @(posedge ld) begin
      sh = ld_byte;
      miso = ld_byte[7];
      skip = skip_first;
   end
   // one edge samples, the other changes; ones follow after the frame
   task automatic on_edge(input logic smp);
      if (smp) begin
         got = {got[6:0], mosi};
      end else if (skip) begin
         skip = 1'b0;
      end else begin
         sh = {sh[6:0], 1'b1};
         miso = sh[7];
      end
   endtask : on_edge
   always @(posedge sclk) begin
      on_edge(~smp_fall);
   end
   always @(negedge sclk) begin
      on_edge(smp_fall);
   end
endmodule : cssf_slave_model
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic clk, rst, start, fault_clear, ext_drv, sel, ld, busy, rx_done, flag, irq, miso, sclk;
   logic [7:0] tx_byte, rx_byte, got, pbyte;
   cssf_pkg::cssf_cfg_t cfg;
   cssf_pkg::cssf_pins_t pins;
   int miscompares, check_count, seed, n;
   logic [7:0] expq[$];
   cssf_top dut (.clk(clk), .rst(rst), .cfg(cfg), .start(start), .tx_byte(tx_byte),
      .fault_clear(fault_clear), .transfer_clock_pin_i(sclk), .serial_in_pin(miso),
      .bus_select_input(sel), .pins(pins), .busy(busy), .rx_byte(rx_byte),
      .rx_done(rx_done), .fault_flag(flag), .fault_irq(irq));
   cssf_slave_model peer (.sclk(sclk), .mosi(pins.out_o), .ld(ld), .ld_byte(pbyte),
      .smp_fall(cfg.pol_rise_out), .skip_first(cfg.phase_delay), .miso(miso), .got(got));
   // clock pin level: ours while driving, else the bench's external clock
   // the bench drives only input-side pins; the design's outputs are never driven
   assign sclk = pins.clk_oe_n ? ext_drv : pins.clk_o;
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : finish_test
   // scoreboard: each posted byte against the oldest note
   always @(posedge clk) begin
      if (rx_done === 1'b1) begin
         if (expq.size() == 0) chk("rx_extra", 8'h00, 8'h01);
         else chk("rx_byte", expq.pop_front(), rx_byte);
      end
   end
   // one byte each way; e is the full-frame cycle figure, h one half period
   task automatic xfer(input cssf_pkg::cssf_src_t s, input logic [7:0] b, input logic x,
         input logic p, input logic d, input int e, input int h);
      logic [7:0] t;
      t = 8'($random(seed));
      pbyte = 8'($random(seed));
      @(posedge clk);
      cfg <= '{master:1'b1, ext_clk:x, pol_rise_out:p, phase_delay:d, src:s, brg:b};
      tx_byte <= t;
      // a mode switch may jog the clock pin, so the peer loads a cycle later
      @(posedge clk);
      ld <= 1'b1;
      @(posedge clk);
      ld <= 1'b0;
      expq.push_back(pbyte);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      n = 1;
      #1;
      chk("busy", 8'h01, {7'h00, busy});
      while (rx_done !== 1'b1 && n < 2000) begin
         @(posedge clk);
         if (x && n <= 64 && n % 4 == 0) ext_drv <= ~ext_drv;
         #1;
         n++;
      end
      chk("rate", 8'h01, 8'(n >= e - 2 * h && n <= e + 1));
      chk("peer_got", t, got);
      chk("clk_oe_n", {7'h00, x}, {7'h00, pins.clk_oe_n});
   endtask : xfer
   // select level and optional clear pulse, then let the syncs settle
   task automatic drive(input logic s, input logic c);
      @(posedge clk);
      sel <= s;
      fault_clear <= c;
      @(posedge clk);
      fault_clear <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
   endtask : drive
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      finish_test();
   end
   initial begin
      seed = 82033;
      miscompares = 0;
      check_count = 0;
      rst = 1'b1;
      start = 1'b0;
      fault_clear = 1'b0;
      ext_drv = 1'b0;
      sel = 1'b1;
      ld = 1'b0;
      tx_byte = 8'h00;
      pbyte = 8'h00;
      cfg = '{master:1'b1, ext_clk:1'b0, pol_rise_out:1'b0, phase_delay:1'b0,
         src:cssf_pkg::CSSF_SRC_DIV1, brg:8'h03};
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      xfer(cssf_pkg::CSSF_SRC_DIV1, 8'h03, 1'b0, 1'b0, 1'b0, 64, 4);
      xfer(cssf_pkg::CSSF_SRC_DIV8, 8'h00, 1'b0, 1'b0, 1'b0, 128, 8);
      xfer(cssf_pkg::CSSF_SRC_DIV32, 8'h00, 1'b0, 1'b0, 1'b0, 512, 32);
      xfer(cssf_pkg::CSSF_SRC_DIV1, 8'h03, 1'b0, 1'b0, 1'b1, 64, 4);
      xfer(cssf_pkg::CSSF_SRC_DIV1, 8'h03, 1'b0, 1'b1, 1'b1, 64, 4);
      xfer(cssf_pkg::CSSF_SRC_DIV1, 8'h03, 1'b0, 1'b1, 1'b0, 64, 4);
      xfer(cssf_pkg::CSSF_SRC_DIV1, 8'h00, 1'b1, 1'b0, 1'b0, 64, 4);
      @(posedge clk);
      cfg.ext_clk <= 1'b0;
      drive(1'b0, 1'b0);
      chk("flag_irq", 8'h03, {6'h00, flag, irq});
      chk("oe_n", 8'h07, {5'h00, pins.clk_oe_n, pins.out_oe_n, pins.in_oe_n});
      drive(1'b0, 1'b1);
      chk("flag_held", 8'h01, {7'h00, flag});
      @(posedge clk);
      cfg.master <= 1'b0;
      drive(1'b0, 1'b1);
      chk("slave_clr", 8'h00, {7'h00, flag});
      drive(1'b0, 1'b0);
      chk("slave_nofault", 8'h00, {7'h00, flag});
      @(posedge clk);
      cfg.master <= 1'b1;
      drive(1'b0, 1'b0);
      drive(1'b1, 1'b0);
      drive(1'b1, 1'b1);
      chk("restored", 8'h00, {6'h00, flag, pins.out_oe_n});
      @(posedge clk);
      cfg.pol_rise_out <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk("clk_idle", 8'h01, {7'h00, pins.clk_o});
      chk("pending", 8'h00, 8'(expq.size()));
      finish_test();
   end
endmodule : testbench
`default_nettype wire
